// *** rtl/lcvpm_map.svh ***
// constants of the line camera video port mapper
// Functional notes
// - only two formats, 8-bit or 10-bit three taps
// - 8-bit: red A, green B, blue C
// - 10-bit: red A plus B0-1, blue C plus B4-5
// - 10-bit: green E plus F0-1, rest empty
// - 8-bit output needs only the first link
// - xclk forwarded on its own, yclk and zclk driven from one shared register
// - 10-bit drives second link, outputs only
// - CC1 starts lines in external trigger mode
// - CC2 encoder used only in average mode
// - CC3 and CC4 are always ignored
// - serial in on SerTC, replies on SerTFG
// - grabber holds unused controls at fixed level
`ifndef LCVPM_MAP_SVH
`define LCVPM_MAP_SVH
`define LCVPM_PIX_W 10
`define LCVPM_PORT_W 8
`define LCVPM_FIFO_DEPTH 8
`define LCVPM_SER_IDLE 1'b1
`define LCVPM_CC_IDLE 1'b0
`endif

// *** rtl/lcvpm_pkg.sv ***
// types of the line camera video port mapper
`include "lcvpm_map.svh"
package lcvpm_pkg;
    typedef logic [`LCVPM_PIX_W-1:0] lcvpm_pix_t;
    typedef logic [`LCVPM_PORT_W-1:0] lcvpm_port_t;
    typedef struct packed {
        logic sol;
        logic eol;
        lcvpm_pix_t red;
        lcvpm_pix_t green;
        lcvpm_pix_t blue;
    } lcvpm_word_t;
endpackage : lcvpm_pkg

// *** rtl/lcvpm_if.sv ***
// link between camera and frame grabber
`timescale 1ns/1ps
interface lcvpm_if;
    lcvpm_pkg::lcvpm_port_t port_a;
    lcvpm_pkg::lcvpm_port_t port_b;
    lcvpm_pkg::lcvpm_port_t port_c;
    lcvpm_pkg::lcvpm_port_t port_d;
    lcvpm_pkg::lcvpm_port_t port_e;
    lcvpm_pkg::lcvpm_port_t port_f;
    lcvpm_pkg::lcvpm_port_t port_g;
    lcvpm_pkg::lcvpm_port_t port_h;
    logic lval;
    logic dval;
    logic xclk;
    logic yclk;
    logic zclk;
    logic cc1;
    logic cc2;
    logic cc3;
    logic cc4;
    logic sertc;
    logic sertfg;
    modport camera (
        output port_a, port_b, port_c, port_d, port_e, port_f, port_g, port_h,
        output lval, dval, xclk, yclk, zclk, sertfg,
        input cc1, cc2, cc3, cc4, sertc
    );
    modport grabber (
        input port_a, port_b, port_c, port_d, port_e, port_f, port_g, port_h,
        input lval, dval, xclk, yclk, zclk, sertfg,
        output cc1, cc2, cc3, cc4, sertc
    );
endinterface : lcvpm_if

// *** rtl/lcvpm_camera.sv ***
// camera end: pixel fifo and port mapper
`timescale 1ns/1ps
`include "lcvpm_map.svh"

module lcvpm_fifo #(
    parameter int W = 32,
    parameter int DEPTH = `LCVPM_FIFO_DEPTH
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [W-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    wire push = ce & in_valid & in_ready;
    wire pop = ce & out_valid & out_ready;

    function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
        next_ptr = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
    endfunction : next_ptr

    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];

    always_ff @(posedge clock) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= next_ptr(wr_q);
            end
            if (pop) begin
                rd_q <= next_ptr(rd_q);
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : lcvpm_fifo

module lcvpm_camera #(
    parameter int DEPTH = `LCVPM_FIFO_DEPTH
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic ce,
    input wire logic pix_valid,
    output logic pix_ready,
    input wire logic pix_sol,
    input wire logic pix_eol,
    input wire lcvpm_pkg::lcvpm_pix_t pix_red,
    input wire lcvpm_pkg::lcvpm_pix_t pix_green,
    input wire lcvpm_pkg::lcvpm_pix_t pix_blue,
    input wire logic wide_sel,
    output logic wide_active,
    input wire logic ext_trig_sel,
    input wire logic avg_mode,
    input wire logic int_line_req,
    output logic line_start,
    output logic encoder_pulse,
    output logic ser_rx,
    input wire logic ser_tx,
    lcvpm_if.camera link
);
    localparam int WW = $bits(lcvpm_pkg::lcvpm_word_t);
    lcvpm_pkg::lcvpm_word_t in_word;
    lcvpm_pkg::lcvpm_word_t out_word;
    logic out_valid;
    logic lclk_q;
    logic yzclk_q;
    logic wide_q;
    logic lval_q;
    logic dval_q;
    lcvpm_pkg::lcvpm_port_t pa_q;
    lcvpm_pkg::lcvpm_port_t pb_q;
    lcvpm_pkg::lcvpm_port_t pc_q;
    lcvpm_pkg::lcvpm_port_t pe_q;
    lcvpm_pkg::lcvpm_port_t pf_q;
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    logic [1:0] prev_q;
    logic line_start_q;
    logic encoder_q;
    logic sertfg_q;

    assign in_word = '{sol: pix_sol, eol: pix_eol, red: pix_red, green: pix_green,
        blue: pix_blue};

    // one word leaves per link clock period, on its falling half
    wire tick = lclk_q;

    lcvpm_fifo #(.W(WW), .DEPTH(DEPTH)) u_fifo (
        .clock(clock),
        .srst(srst),
        .ce(ce),
        .in_valid(pix_valid),
        .in_ready(pix_ready),
        .in_data(in_word),
        .out_valid(out_valid),
        .out_ready(tick),
        .out_data(out_word)
    );

    wire take = tick & out_valid;
    // the first word of a line picks up the new width
    wire use_wide = (take & out_word.sol) ? wide_sel : wide_q;
    wire lval_d = take ? ~out_word.eol : (lval_q & ~tick);

    // only two layouts exist, selected by use_wide
    wire [`LCVPM_PORT_W-1:0] map_a = out_word.red[7:0];
    wire [`LCVPM_PORT_W-1:0] map_b = use_wide ?
        {2'h0, out_word.blue[9:8], 2'h0, out_word.red[9:8]} :
        out_word.green[7:0];
    wire [`LCVPM_PORT_W-1:0] map_c = out_word.blue[7:0];
    wire [`LCVPM_PORT_W-1:0] map_e = use_wide ? out_word.green[7:0] : 8'h00;
    wire [`LCVPM_PORT_W-1:0] map_f = use_wide ? {6'h00, out_word.green[9:8]} : 8'h00;

    // link clock: divide by two, data changes on its falling edge
    always_ff @(posedge clock) begin
        if (srst) begin
            lclk_q <= 1'b0;
            yzclk_q <= 1'b0;
        end else if (ce) begin
            lclk_q <= ~lclk_q;
            yzclk_q <= wide_q & ~lclk_q;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            wide_q <= 1'b0;
            lval_q <= 1'b0;
            dval_q <= 1'b0;
        end else if (ce) begin
            if (take && out_word.sol) begin
                wide_q <= wide_sel;
            end
            if (tick) begin
                dval_q <= out_valid;
                lval_q <= take | lval_d;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            pa_q <= 8'h00;
            pb_q <= 8'h00;
            pc_q <= 8'h00;
            pe_q <= 8'h00;
            pf_q <= 8'h00;
        end else if (ce && tick) begin
            pa_q <= out_valid ? map_a : 8'h00;
            pb_q <= out_valid ? map_b : 8'h00;
            pc_q <= out_valid ? map_c : 8'h00;
            pe_q <= out_valid ? map_e : 8'h00;
            pf_q <= out_valid ? map_f : 8'h00;
        end
    end

    assign link.port_a = pa_q;
    assign link.port_b = pb_q;
    assign link.port_c = pc_q;
    assign link.port_d = 8'h00;
    assign link.port_e = pe_q;
    assign link.port_f = pf_q;
    assign link.port_g = 8'h00;
    assign link.port_h = 8'h00;
    assign link.lval = lval_q;
    assign link.dval = dval_q;
    assign link.xclk = lclk_q;
    assign link.yclk = yzclk_q;
    assign link.zclk = yzclk_q;
    assign link.sertfg = sertfg_q;
    assign wide_active = wide_q;

    // control pins: cc1, cc2, sertc; cc3 and cc4 are never sampled
    wire cc1_s = sync2_q[0];
    wire cc2_s = sync2_q[1];
    wire cc1_rise = cc1_s & ~prev_q[0];
    wire cc2_rise = cc2_s & ~prev_q[1];
    wire line_start_d = ext_trig_sel ? cc1_rise : int_line_req;
    wire encoder_d = avg_mode & cc2_rise;

    always_ff @(posedge clock) begin
        if (srst) begin
            sync1_q <= {`LCVPM_SER_IDLE, `LCVPM_CC_IDLE, `LCVPM_CC_IDLE};
            sync2_q <= {`LCVPM_SER_IDLE, `LCVPM_CC_IDLE, `LCVPM_CC_IDLE};
            prev_q <= 2'h0;
            line_start_q <= 1'b0;
            encoder_q <= 1'b0;
            sertfg_q <= `LCVPM_SER_IDLE;
        end else if (ce) begin
            sync1_q <= {link.sertc, link.cc2, link.cc1};
            sync2_q <= sync1_q;
            prev_q <= {cc2_s, cc1_s};
            line_start_q <= line_start_d;
            encoder_q <= encoder_d;
            sertfg_q <= ser_tx;
        end
    end

    assign line_start = line_start_q;
    assign encoder_pulse = encoder_q;
    assign ser_rx = sync2_q[2];
endmodule : lcvpm_camera

// *** rtl/lcvpm_grabber.sv ***
// frame grabber end: port unpacking and control outputs
`timescale 1ns/1ps
`include "lcvpm_map.svh"

module lcvpm_grabber (
    input wire logic clock,
    input wire logic srst,
    input wire logic ce,
    input wire logic trig_level,
    input wire logic encoder_level,
    input wire logic ser_tx,
    output logic ser_rx,
    input wire logic wide_sel,
    output logic rx_valid,
    output logic rx_sol,
    output lcvpm_pkg::lcvpm_pix_t rx_red,
    output lcvpm_pkg::lcvpm_pix_t rx_green,
    output lcvpm_pkg::lcvpm_pix_t rx_blue,
    lcvpm_if.grabber link
);
    logic cc1_q;
    logic cc2_q;
    logic sertc_q;
    logic ser1_q;
    logic ser2_q;
    logic rst1_q;
    logic rst2_q;
    logic wide1_q;
    logic wide2_q;
    logic lval_prev_q;
    logic valid_q;
    logic sol_q;
    lcvpm_pkg::lcvpm_pix_t red_q;
    lcvpm_pkg::lcvpm_pix_t green_q;
    lcvpm_pkg::lcvpm_pix_t blue_q;

    // control outputs, system clock
    always_ff @(posedge clock) begin
        if (srst) begin
            cc1_q <= `LCVPM_CC_IDLE;
            cc2_q <= `LCVPM_CC_IDLE;
            sertc_q <= `LCVPM_SER_IDLE;
            ser1_q <= `LCVPM_SER_IDLE;
            ser2_q <= `LCVPM_SER_IDLE;
        end else if (ce) begin
            cc1_q <= trig_level;
            cc2_q <= encoder_level;
            sertc_q <= ser_tx;
            ser1_q <= link.sertfg;
            ser2_q <= ser1_q;
        end
    end

    assign link.cc1 = cc1_q;
    assign link.cc2 = cc2_q;
    assign link.cc3 = `LCVPM_CC_IDLE;
    assign link.cc4 = `LCVPM_CC_IDLE;
    assign link.sertc = sertc_q;
    assign ser_rx = ser2_q;

    // link domain: reset and width setting brought onto xclk
    always_ff @(posedge link.xclk) begin
        rst1_q <= srst;
        rst2_q <= rst1_q;
        wide1_q <= wide_sel;
        wide2_q <= wide1_q;
    end

    wire [`LCVPM_PIX_W-1:0] red_d = wide2_q ? {link.port_b[1:0], link.port_a} :
        {2'h0, link.port_a};
    wire [`LCVPM_PIX_W-1:0] blue_d = wide2_q ? {link.port_b[5:4], link.port_c} :
        {2'h0, link.port_c};
    wire [`LCVPM_PIX_W-1:0] green_d = wide2_q ? {link.port_f[1:0], link.port_e} :
        {2'h0, link.port_b};

    always_ff @(posedge link.xclk) begin
        if (rst2_q) begin
            lval_prev_q <= 1'b0;
            valid_q <= 1'b0;
            sol_q <= 1'b0;
            red_q <= '0;
            green_q <= '0;
            blue_q <= '0;
        end else begin
            lval_prev_q <= link.lval;
            valid_q <= link.dval;
            sol_q <= link.dval & ~lval_prev_q;
            red_q <= red_d;
            green_q <= green_d;
            blue_q <= blue_d;
        end
    end

    assign rx_valid = valid_q;
    assign rx_sol = sol_q;
    assign rx_red = red_q;
    assign rx_green = green_q;
    assign rx_blue = blue_q;
endmodule : lcvpm_grabber

// *** test/lcvpm_props.sv ***
// assertions on the camera to grabber link
`timescale 1ns/1ps
module lcvpm_props (
    input wire logic clock,
    input wire logic srst,
    input wire lcvpm_pkg::lcvpm_port_t port_a,
    input wire lcvpm_pkg::lcvpm_port_t port_c,
    input wire lcvpm_pkg::lcvpm_port_t port_d,
    input wire lcvpm_pkg::lcvpm_port_t port_e,
    input wire lcvpm_pkg::lcvpm_port_t port_f,
    input wire lcvpm_pkg::lcvpm_port_t port_g,
    input wire lcvpm_pkg::lcvpm_port_t port_h,
    input wire logic lval,
    input wire logic dval,
    input wire logic xclk,
    input wire logic yclk,
    input wire logic zclk,
    input wire logic cc3,
    input wire logic cc4
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    sequence s_rise;
        $rose(xclk);
    endsequence
    sequence s_fall;
        $fell(xclk);
    endsequence
    a_spare_ports_zero: assert property (
        port_d == 8'h00 && port_g == 8'h00 && port_h == 8'h00) else $error("spare port carries data");
    a_upper_f_zero: assert property (port_f[7:2] == 6'h00)
        else $error("port f upper bits set");
    a_idle_ports_zero: assert property (
        !dval |-> port_a == 8'h00 && port_c == 8'h00 && port_e == 8'h00) else $error("data without dval");
    a_base_link_quiet: assert property (
        (!yclk)[*4] |-> $past(port_e) == 8'h00 && $past(port_f) == 8'h00)
        else $error("second link used while stopped");
    a_forward_clocks_aligned: assert property (
        yclk == zclk && (!yclk || xclk)) else $error("forwarded clocks out of step");
    a_xclk_half_rate: assert property (s_rise |=> s_fall)
        else $error("xclk not at half rate");
    a_ports_on_fall: assert property (!$stable(port_a) |-> s_fall)
        else $error("port changed off the falling xclk");
    a_dval_in_line: assert property (dval |-> lval)
        else $error("word outside a line");
    a_spare_cc_low: assert property (!cc3 && !cc4)
        else $error("spare control not held low");
endmodule : lcvpm_props

// *** test/lcvpm_test.sv ***
// camera and grabber joined over the link, self-checking
`timescale 1ns/1ps
module lcvpm_test;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic pix_valid = 1'b0, pix_sol = 1'b0, pix_eol = 1'b0, wide_cam = 1'b0, wide_grb = 1'b0;
    logic ext_trig = 1'b0, avg = 1'b0, int_req = 1'b0, trig_lvl = 1'b0, enc_lvl = 1'b0;
    logic tx_cam = 1'b1, tx_grb = 1'b1;
    lcvpm_pkg::lcvpm_pix_t pix_red = 10'h000, pix_green = 10'h000, pix_blue = 10'h000;
    logic pix_ready, wide_active, line_start, encoder_pulse, rx_cam, rx_grb, rx_valid, rx_sol;
    lcvpm_pkg::lcvpm_pix_t rx_red, rx_green, rx_blue;
    lcvpm_pkg::lcvpm_word_t exp_q[$], got_q[$];
    int failures = 0, tests_run = 0, cycles = 0, ls_cnt = 0, enc_cnt = 0;
    logic full_seen = 1'b0;
    lcvpm_if lk();
    lcvpm_camera u_lcvpm_camera (.clock(clock), .srst(srst), .ce(1'b1), .pix_valid(pix_valid),
        .pix_ready(pix_ready), .pix_sol(pix_sol), .pix_eol(pix_eol), .pix_red(pix_red),
        .pix_green(pix_green), .pix_blue(pix_blue), .wide_sel(wide_cam),
        .wide_active(wide_active), .ext_trig_sel(ext_trig), .avg_mode(avg),
        .int_line_req(int_req), .line_start(line_start), .encoder_pulse(encoder_pulse),
        .ser_rx(rx_cam), .ser_tx(tx_cam), .link(lk.camera));
    lcvpm_grabber u_lcvpm_grabber (.clock(clock), .srst(srst), .ce(1'b1), .trig_level(trig_lvl),
        .encoder_level(enc_lvl), .ser_tx(tx_grb), .ser_rx(rx_grb), .wide_sel(wide_grb),
        .rx_valid(rx_valid), .rx_sol(rx_sol), .rx_red(rx_red), .rx_green(rx_green),
        .rx_blue(rx_blue), .link(lk.grabber));
    lcvpm_props u_lcvpm_props (.clock(clock), .srst(srst), .port_a(lk.port_a), .port_c(lk.port_c),
        .port_d(lk.port_d), .port_e(lk.port_e), .port_f(lk.port_f), .port_g(lk.port_g),
        .port_h(lk.port_h), .lval(lk.lval), .dval(lk.dval), .xclk(lk.xclk), .yclk(lk.yclk),
        .zclk(lk.zclk), .cc3(lk.cc3), .cc4(lk.cc4));
    always #5 clock = ~clock;
    // rx word stands one xclk period, so one sample per rise
    always @(posedge lk.xclk) begin
        if (rx_valid === 1'b1) got_q.push_back({rx_sol, 1'b0, rx_red, rx_green, rx_blue});
    end
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (line_start === 1'b1) ls_cnt <= ls_cnt + 1;
        if (encoder_pulse === 1'b1) enc_cnt <= enc_cnt + 1;
        if (pix_ready === 1'b0) full_seen <= 1'b1;
        if (cycles == 6000) begin
            failures = failures + 1;
            end_of_test();
        end
    end
    task chk_val(string what, logic [31:0] exp, logic [31:0] got);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_val
    task run_line(logic wide, int n, logic flip);
        lcvpm_pkg::lcvpm_word_t w;
        wide_grb <= wide;
        exp_q.delete();
        got_q.delete();
        repeat (8) @(posedge clock);
        for (int i = 0; i < n; i++) begin
            w.sol = (i == 0);
            w.eol = 1'b0;
            w.red = 10'(10'h2A5 + i * 10'h013);
            w.green = 10'(10'h15A + i * 10'h029);
            w.blue = 10'(10'h3C3 + i * 10'h007);
            pix_valid <= 1'b1;
            pix_sol <= w.sol;
            pix_eol <= (i == n - 1);
            pix_red <= w.red;
            pix_green <= w.green;
            pix_blue <= w.blue;
            if (i == 0) wide_cam <= wide;
            if (flip && i == n - 1) wide_cam <= !wide;
            if (!wide) begin
                w.red[9:8] = 2'h0;
                w.green[9:8] = 2'h0;
                w.blue[9:8] = 2'h0;
            end
            exp_q.push_back(w);
            do @(posedge clock); while (pix_ready !== 1'b1);
        end
        pix_valid <= 1'b0;
        for (int k = 0; k < 300 && got_q.size() < n; k++) @(posedge clock);
        chk_val("word count", n, got_q.size());
        foreach (exp_q[k]) if (k < got_q.size()) chk_val("word", exp_q[k], got_q[k]);
    endtask : run_line
    task t_base_line();
        run_line(1'b0, 6, 1'b0);
        chk_val("yclk stopped", 1'b0, lk.yclk);
        chk_val("no refusal", 1'b0, full_seen);
    endtask : t_base_line
    task t_medium_fill();
        run_line(1'b1, 20, 1'b0);
        chk_val("fifo refused", 1'b1, full_seen);
    endtask : t_medium_fill
    task t_width_at_sol();
        run_line(1'b0, 5, 1'b1);
        chk_val("width kept", 1'b0, wide_active);
        run_line(1'b1, 4, 1'b0);
        chk_val("width taken", 1'b1, wide_active);
    endtask : t_width_at_sol
    task t_trigger();
        int c;
        c = ls_cnt;
        trig_lvl <= 1'b1;
        repeat (10) @(posedge clock);
        chk_val("cc1 ignored", c, ls_cnt);
        ext_trig <= 1'b1;
        trig_lvl <= 1'b0;
        repeat (10) @(posedge clock);
        trig_lvl <= 1'b1;
        repeat (10) @(posedge clock);
        chk_val("cc1 line start", c + 1, ls_cnt);
        ext_trig <= 1'b0;
        int_req <= 1'b1;
        @(posedge clock);
        int_req <= 1'b0;
        repeat (4) @(posedge clock);
        chk_val("internal line start", c + 2, ls_cnt);
    endtask : t_trigger
    task t_encoder();
        int c;
        c = enc_cnt;
        enc_lvl <= 1'b1;
        repeat (10) @(posedge clock);
        chk_val("cc2 ignored", c, enc_cnt);
        avg <= 1'b1;
        enc_lvl <= 1'b0;
        repeat (10) @(posedge clock);
        enc_lvl <= 1'b1;
        repeat (10) @(posedge clock);
        chk_val("cc2 encoder", c + 1, enc_cnt);
    endtask : t_encoder
    task t_serial();
        tx_grb <= 1'b0;
        repeat (5) @(posedge clock);
        chk_val("camera serial in", 2'h1, {rx_cam, rx_grb});
        tx_grb <= 1'b1;
        tx_cam <= 1'b0;
        repeat (5) @(posedge clock);
        chk_val("grabber serial in", 2'h2, {rx_cam, rx_grb});
        tx_cam <= 1'b1;
    endtask : t_serial
    task end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test
    initial begin
        repeat (6) @(posedge clock);
        srst <= 1'b0;
        repeat (4) @(posedge clock);
        t_base_line();
        t_medium_fill();
        t_width_at_sol();
        t_trigger();
        t_encoder();
        t_serial();
        end_of_test();
    end
endmodule : lcvpm_test
